// ---- hdl/oat_pkg.sv ----
// Purpose: constants and types shared by the amplifier control and offset trim block
// Assumes: 200 MHz system clock, 32-bit AHB-Lite register access
// Notes:   offsets are byte addresses; one 8-bit register per aligned word

package oat_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] ADDR_TRIM     = 12'h110;
  localparam logic [11:0] ADDR_AMP      = 12'h11c;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h120;
  localparam logic [11:0] ADDR_IRQ_EN   = 12'h124;
  localparam logic [11:0] ADDR_IRQ_CLR  = 12'h128;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int AMP_EN_BIT     = 7;
  localparam int CMP_SEL_BIT    = 6;
  localparam int BW_SEL_BIT     = 0;
  localparam int TRIM_START_BIT = 7;
  localparam int TRIM_FAIL_BIT  = 6;
  localparam int TRIM_REF_BIT   = 5;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_FAIL_BIT   = 1;
  localparam int IRQ_W          = 2;

  localparam logic [7:0]        REG8_RESET  = 8'h00;
  localparam logic [IRQ_W-1:0]  IRQ_RESET   = 2'h0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 5;
  // analog settling per trial step, a least time so it rounds up
  localparam int SETTLE_NS     = 1000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // bus codes
  // ************************************************************
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic       HRESP_OKAY  = 1'b0;

  typedef enum logic [1:0] {TRIM_IDLE, TRIM_SETTLE, TRIM_CHECK} oat_trim_e;

endpackage : oat_pkg

// ---- hdl/oat_amp_trim.sv ----
// Purpose: register control of the on-chip amplifier and its offset trim engine
// Assumes: AHB-Lite single word transfers, comparator sense from the analog trim loop
// Notes:   zero wait states; trim is a successive approximation of the trim code
//
// The implementer's own choice: the AHB-Lite slave port.

`timescale 1ns/100ps
`default_nettype none

module oat_amp_trim
  import oat_pkg::*;
#(
  parameter int TRIM_W     = 5,
  parameter int SETTLE_CYC = SETTLE_CYCLES
)(
  input  wire  logic              clock,
  input  wire  logic              sys_rst,
  input  wire  logic              hsel,
  input  wire  logic [31:0]       haddr,
  input  wire  logic [1:0]        htrans,
  input  wire  logic              hwrite,
  input  wire  logic [2:0]        hsize,
  input  wire  logic [31:0]       hwdata,
  input  wire  logic              hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire  logic              trimCompare,
  output logic                    ampEnable,
  output logic                    comparatorSelect,
  output logic                    bandwidthSelect,
  output logic                    trimRefSelect,
  output logic                    trimBusy,
  output logic [TRIM_W-1:0]       trimCode,
  output logic                    ampOutputDrive,
  output logic                    portDriverOff,
  output logic                    irq
);

  // ************************************************************
  // bus slave
  // ************************************************************
  logic        wrPend;
  logic [11:0] wrAddr;
  logic        addrPhase;
  logic        rdReq;
  logic        wrTrim;
  logic        wrAmp;
  logic        wrIrqEn;
  logic        wrIrqClr;

  // hsize is not checked: only whole-word transfers are issued
  assign addrPhase = hsel & htrans[1] & hready;
  assign rdReq     = addrPhase & ~hwrite;
  assign wrTrim    = wrPend && (wrAddr == ADDR_TRIM);
  assign wrAmp     = wrPend && (wrAddr == ADDR_AMP);
  assign wrIrqEn   = wrPend && (wrAddr == ADDR_IRQ_EN);
  assign wrIrqClr  = wrPend && (wrAddr == ADDR_IRQ_CLR);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wrPend <= 1'b0;
      wrAddr <= 12'h000;
    end
    else
    begin
      wrPend <= addrPhase & hwrite;
      wrAddr <= haddr[11:0];
    end
  end

  // ************************************************************
  // amplifier control
  // ************************************************************
  logic next_ampEnable;
  logic next_comparatorSelect;
  logic next_bandwidthSelect;
  logic next_trimRefSelect;

  assign next_ampEnable        = wrAmp ? hwdata[AMP_EN_BIT] : ampEnable;
  assign next_comparatorSelect = wrAmp ? hwdata[CMP_SEL_BIT] : comparatorSelect;
  assign next_bandwidthSelect  = wrAmp ? hwdata[BW_SEL_BIT] : bandwidthSelect;
  assign next_trimRefSelect    = wrTrim ? hwdata[TRIM_REF_BIT] : trimRefSelect;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ampEnable        <= 1'b0;
      comparatorSelect <= 1'b0;
      bandwidthSelect  <= 1'b0;
      trimRefSelect    <= 1'b0;
    end
    else
    begin
      ampEnable        <= next_ampEnable;
      comparatorSelect <= next_comparatorSelect;
      bandwidthSelect  <= next_bandwidthSelect;
      trimRefSelect    <= next_trimRefSelect;
    end
  end

  // ************************************************************
  // comparator sense synchroniser
  // ************************************************************
  // sense arrives two edges after trimCode, itself one edge behind the trial code, so a settle count below four judges a stale level
  logic cmpMeta;
  logic cmpSync;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cmpMeta <= 1'b0;
      cmpSync <= 1'b0;
    end
    else
    begin
      cmpMeta <= trimCompare;
      cmpSync <= cmpMeta;
    end
  end

  // ************************************************************
  // offset trim engine
  // ************************************************************
  // index width of one trial bit; a plain name keeps the size casts simple
  localparam int IDX_W = $clog2(TRIM_W);

  function automatic logic [TRIM_W-1:0] bitOf(input logic [$clog2(TRIM_W)-1:0] idx);
    logic [TRIM_W-1:0] m;
    m      = '0;
    m[idx] = 1'b1;
    return m;
  endfunction : bitOf

  oat_trim_e                  trimState;
  logic [$clog2(TRIM_W)-1:0]  bitIdx;
  logic [15:0]                settleCnt;
  logic [TRIM_W-1:0]          trialCode;
  logic [TRIM_W-1:0]          appliedCode;
  logic                       trimStart;
  logic                       trimFail;
  logic                       startReq;
  logic                       finish;
  logic                       railed;
  logic                       stepDone;
  logic                       next_trimStart;
  logic                       next_trimFail;
  logic [TRIM_W-1:0]          next_appliedCode;

  // a start while busy is ignored; a written 0 cannot abort the engine
  assign startReq  = wrTrim & hwdata[TRIM_START_BIT] & (trimState == TRIM_IDLE);
  assign finish    = (trimState == TRIM_CHECK);
  assign stepDone  = (settleCnt == 16'(SETTLE_CYC - 1));
  // a code pinned at either end means the offset was outside trim range
  assign railed    = (trialCode == '0) || (trialCode == '1);
  assign next_trimStart = startReq | (trimStart & ~finish);
  assign next_trimFail  = ~startReq & (trimFail | (finish & railed));
  // the stored code as it stands after this edge, so the trim output never
  // shows the previous result for a cycle at the end of a run
  assign next_appliedCode = (finish && !railed) ? trialCode : appliedCode;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      trimState   <= TRIM_IDLE;
      bitIdx      <= '0;
      settleCnt   <= 16'h0000;
      trialCode   <= '0;
      appliedCode <= '0;
    end
    else
    begin
      case (trimState)
        TRIM_IDLE:
        begin
          if (startReq)
          begin
            trimState <= TRIM_SETTLE;
            bitIdx    <= IDX_W'(TRIM_W - 1);
            trialCode <= bitOf(IDX_W'(TRIM_W - 1));
            settleCnt <= 16'h0000;
          end
        end
        TRIM_SETTLE:
        begin
          settleCnt <= stepDone ? 16'h0000 : settleCnt + 16'h0001;
          if (stepDone)
          begin
            // sense low means the trial bit overshot
            if (!cmpSync)
              trialCode <= trialCode & ~bitOf(bitIdx);
            if (bitIdx == '0)
              trimState <= TRIM_CHECK;
            else
            begin
              bitIdx    <= bitIdx - 1'b1;
              trialCode <= (cmpSync ? trialCode : trialCode & ~bitOf(bitIdx))
                           | bitOf(bitIdx - 1'b1);
            end
          end
        end
        TRIM_CHECK:
        begin
          trimState <= TRIM_IDLE;
          if (!railed)
            appliedCode <= trialCode;
        end
        default:
          trimState <= TRIM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      trimStart <= 1'b0;
      trimFail  <= 1'b0;
    end
    else
    begin
      trimStart <= next_trimStart;
      trimFail  <= next_trimFail;
    end
  end

  // ************************************************************
  // interrupts
  // ************************************************************
  logic [IRQ_W-1:0] irqStatus;
  logic [IRQ_W-1:0] irqEnable;
  logic [IRQ_W-1:0] irqEvent;
  logic [IRQ_W-1:0] irqClr;
  logic [IRQ_W-1:0] next_irqStatus;
  logic [IRQ_W-1:0] next_irqEnable;

  assign irqEvent[IRQ_DONE_BIT] = finish;
  assign irqEvent[IRQ_FAIL_BIT] = finish & railed;
  assign irqClr         = wrIrqClr ? hwdata[IRQ_W-1:0] : IRQ_RESET;
  // an event in the clearing cycle survives the clear
  assign next_irqStatus = (irqStatus & ~irqClr) | irqEvent;
  assign next_irqEnable = wrIrqEn ? hwdata[IRQ_W-1:0] : irqEnable;

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      irqStatus <= IRQ_RESET;
      irqEnable <= IRQ_RESET;
    end
    else
    begin
      irqStatus <= next_irqStatus;
      irqEnable <= next_irqEnable;
    end
  end

  // ************************************************************
  // read mux and registered outputs
  // ************************************************************
  logic [11:0]       rdAddr;
  logic              rdTrim;
  logic              rdAmp;
  logic              rdStat;
  logic              rdIrqEn;
  logic [7:0]        trimRead;
  logic [7:0]        ampRead;
  logic [31:0]       next_hrdata;
  logic [TRIM_W-1:0] next_trimCode;
  logic              next_ampOutputDrive;
  logic              next_portDriverOff;
  logic              next_irq;

  // built from next values so a read right behind a write sees the new data
  assign rdAddr   = haddr[11:0];
  assign rdTrim   = (rdAddr == ADDR_TRIM);
  assign rdAmp    = (rdAddr == ADDR_AMP);
  assign rdStat   = (rdAddr == ADDR_IRQ_STAT);
  assign rdIrqEn  = (rdAddr == ADDR_IRQ_EN);
  assign trimRead = {next_trimStart, next_trimFail, next_trimRefSelect, 5'h00};
  assign ampRead  = {next_ampEnable, next_comparatorSelect, 5'h00, next_bandwidthSelect};
  assign next_hrdata =
      !rdReq  ? 32'h0000_0000 :
      rdTrim  ? {24'h00_0000, trimRead} :
      rdAmp   ? {24'h00_0000, ampRead} :
      rdStat  ? {30'h0000_0000, next_irqStatus} :
      rdIrqEn ? {30'h0000_0000, next_irqEnable} :
                32'h0000_0000;

  // pin controls follow the next register values so they move at the write edge
  assign next_trimCode       = next_trimStart ? trialCode : next_appliedCode;
  assign next_ampOutputDrive = next_ampEnable & ~next_trimStart;
  assign next_portDriverOff  = next_ampEnable | next_trimStart;
  assign next_irq            = |(next_irqStatus & next_irqEnable);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      hreadyout      <= 1'b1;
      hresp          <= HRESP_OKAY;
      hrdata         <= 32'h0000_0000;
      trimBusy       <= 1'b0;
      trimCode       <= '0;
      ampOutputDrive <= 1'b0;
      portDriverOff  <= 1'b0;
      irq            <= 1'b0;
    end
    else
    begin
      hreadyout      <= 1'b1;
      hresp          <= HRESP_OKAY;
      hrdata         <= next_hrdata;
      trimBusy       <= next_trimStart;
      trimCode       <= next_trimCode;
      ampOutputDrive <= next_ampOutputDrive;
      portDriverOff  <= next_portDriverOff;
      irq            <= next_irq;
    end
  end

endmodule : oat_amp_trim

`default_nettype wire

// ---- verification/oat_chk_checker.sv ----
// Purpose: port level checks of oat_amp_trim
// Assumes: zero wait bus, outputs move at the data edge
// Notes:   bound below; covers show the main runs
`timescale 1ns/100ps
`default_nettype none
module oat_chk
  import oat_pkg::*;
#(
  parameter int TRIM_W     = 5,
  parameter int SETTLE_CYC = SETTLE_CYCLES
)(
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              ampEnable,
  input wire logic              comparatorSelect,
  input wire logic              bandwidthSelect,
  input wire logic              trimRefSelect,
  input wire logic              trimBusy,
  input wire logic [TRIM_W-1:0] trimCode,
  input wire logic              ampOutputDrive,
  input wire logic              portDriverOff,
  input wire logic              irq
);
  // ********
  // decode of write address phases
  // ********
  localparam int TMAX = 300;
  wire logic wrAny = hsel & htrans[1] & hready & hwrite;
  wire logic wrA   = wrAny & (haddr[11:0] == ADDR_AMP);
  wire logic wrT   = wrAny & (haddr[11:0] == ADDR_TRIM);

  // busy cycles of the current run, for the exact length of a trim
  logic [15:0] busyLen;
  always_ff @(posedge clock)
    if (sys_rst || !trimBusy)
      busyLen <= 16'h0000;
    else
      busyLen <= busyLen + 16'h0001;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  chk_amp_enable: assert property (wrA |=> ##1 ampEnable == $past(hwdata[AMP_EN_BIT]))
    else $error("amp enable not taken from write");
  chk_cmp_mode: assert property (wrA |=> ##1 comparatorSelect == $past(hwdata[CMP_SEL_BIT]))
    else $error("comparator select not taken from write");
  chk_bw_mode: assert property (wrA |=> ##1 bandwidthSelect == $past(hwdata[BW_SEL_BIT]))
    else $error("bandwidth select not taken from write");
  chk_ref_sel: assert property (wrT |=> ##1 trimRefSelect == $past(hwdata[TRIM_REF_BIT]))
    else $error("trim reference not taken from write");
  chk_trim_launch: assert property (wrT && !trimBusy |=> ##1 trimBusy == $past(hwdata[7]))
    else $error("trim start not launched");
  chk_trim_ends: assert property ($rose(trimBusy) |-> trimBusy[*8] ##[1:TMAX] !trimBusy)
    else $error("trim busy length wrong");
  chk_trim_length: assert property ($fell(trimBusy) |-> busyLen == TRIM_W * SETTLE_CYC + 1)
    else $error("trim run length wrong");
  chk_port_off: assert property (portDriverOff == (ampEnable | trimBusy))
    else $error("port driver not released");
  chk_pin_float: assert property (ampOutputDrive == (ampEnable & !trimBusy))
    else $error("amplifier pin drive wrong");
  chk_code_held: assert property (!trimBusy ##1 !trimBusy |-> $stable(trimCode))
    else $error("stored trim code moved");
  chk_reset_clear: assert property (disable iff (1'b0) sys_rst |=> !ampEnable && !trimBusy
    && trimCode == '0 && !irq && !portDriverOff)
    else $error("reset left state behind");

  cover property ($fell(trimBusy));
  cover property ($rose(irq));
  cover property (wrA ##2 ampEnable);
endmodule : oat_chk

bind oat_amp_trim oat_chk #(.TRIM_W(TRIM_W), .SETTLE_CYC(SETTLE_CYC)) chk (.clock(clock),
  .sys_rst(sys_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .ampEnable(ampEnable), .comparatorSelect(comparatorSelect),
  .bandwidthSelect(bandwidthSelect), .trimRefSelect(trimRefSelect), .trimBusy(trimBusy),
  .trimCode(trimCode), .ampOutputDrive(ampOutputDrive), .portDriverOff(portDriverOff),
  .irq(irq));
`default_nettype wire

// ---- verification/oat_tb.sv ----
// Purpose: bus level tests of oat_amp_trim
// Assumes: AHB-Lite master, settle shortened to 8 cycles
// Notes:   trimCompare is scripted per trim run
`timescale 1ns/100ps
`default_nettype none
module tb;
  import oat_pkg::*;
  // ********
  // stimulus and tasks
  // ********
  localparam int SC = 8;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = HTRANS_IDLE;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        cmpIn = 1'b0;
  logic        hreadyout, hresp, ampEnable, comparatorSelect, bandwidthSelect;
  logic        trimRefSelect, trimBusy, ampOutputDrive, portDriverOff, irq;
  logic [31:0] hrdata, rd;
  logic [4:0]  trimCode;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  logic [31:0] ampv [4] = '{32'hffffffff, 32'h41, 32'h0, 32'h81};
  logic [11:0] map [5] = '{ADDR_TRIM, ADDR_AMP, ADDR_IRQ_STAT, ADDR_IRQ_EN, 12'h200};

  always #2.5 clock = ~clock;

  oat_amp_trim #(.TRIM_W(5), .SETTLE_CYC(SC)) dut (.clock(clock), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .trimCompare(cmpIn), .ampEnable(ampEnable),
    .comparatorSelect(comparatorSelect), .bandwidthSelect(bandwidthSelect),
    .trimRefSelect(trimRefSelect), .trimBusy(trimBusy), .trimCode(trimCode),
    .ampOutputDrive(ampOutputDrive), .portDriverOff(portDriverOff), .irq(irq));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // ends half a cycle after the data edge so registered outputs have settled
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", hresp, HRESP_OKAY);
    @(negedge clock);
  endtask : bus

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rdchk

  task automatic regs_zero;
    for (int i = 0; i < 5; i++)
      rdchk("reset reg", map[i], 32'h0);
  endtask : regs_zero

  // c0 is the compare level at start; sw drops it after the first trial bit
  task automatic run(input logic c0, input logic sw, input logic [4:0] code, input logic f);
    bus(1'b1, ADDR_IRQ_CLR, 32'h3);
    @(posedge clock);
    cmpIn <= c0;
    bus(1'b1, ADDR_TRIM, 32'h80);
    chk("busy", trimBusy, 1'b1);
    chk("pin drive", ampOutputDrive, 1'b0);
    chk("port off", portDriverOff, 1'b1);
    if (sw)
    begin
      repeat (12) @(posedge clock);
      cmpIn <= 1'b0;
      bus(1'b1, ADDR_TRIM, 32'h0);
      chk("no abort", trimBusy, 1'b1);
    end
    while (trimBusy !== 1'b0) @(posedge clock);
    @(negedge clock);
    rdchk("trim ctl", ADDR_TRIM, f ? 32'h40 : 32'h0);
    chk("trim code", trimCode, code);
    chk("pin drive", ampOutputDrive, 1'b1);
    rdchk("status", ADDR_IRQ_STAT, f ? 32'h3 : 32'h1);
  endtask : run

  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  // ********
  // main sequence
  // ********
  initial
  begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    bus(1'b1, 12'h200, 32'hff);
    regs_zero();
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, ADDR_AMP, ampv[i]);
      chk("amp en", ampEnable, ampv[i][7]);
      chk("cmp sel", comparatorSelect, ampv[i][6]);
      chk("bw sel", bandwidthSelect, ampv[i][0]);
      chk("port off", portDriverOff, ampv[i][7]);
      if (i == 0)
        rdchk("amp ctl", ADDR_AMP, 32'hc1);
    end
    bus(1'b1, ADDR_TRIM, 32'h60);
    rdchk("trim ctl", ADDR_TRIM, 32'h20);
    chk("ref sel", trimRefSelect, 1'b1);
    bus(1'b1, ADDR_TRIM, 32'h0);
    chk("ref sel", trimRefSelect, 1'b0);
    repeat (20) @(posedge clock);
    run(1'b1, 1'b0, 5'h00, 1'b1);
    run(1'b1, 1'b1, 5'h10, 1'b0);
    run(1'b0, 1'b0, 5'h10, 1'b1);
    chk("irq masked", irq, 1'b0);
    bus(1'b1, ADDR_IRQ_EN, 32'h3);
    rdchk("irq en", ADDR_IRQ_EN, 32'h3);
    chk("irq", irq, 1'b1);
    bus(1'b1, ADDR_IRQ_CLR, 32'h1);
    rdchk("status", ADDR_IRQ_STAT, 32'h2);
    chk("irq", irq, 1'b1);
    bus(1'b1, ADDR_IRQ_EN, 32'h1);
    chk("irq masked", irq, 1'b0);
    bus(1'b1, ADDR_IRQ_CLR, 32'h2);
    rdchk("status", ADDR_IRQ_STAT, 32'h0);
    rdchk("irq clr", ADDR_IRQ_CLR, 32'h0);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    chk("code reset", trimCode, 5'h00);
    chk("amp reset", ampEnable, 1'b0);
    regs_zero();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
